/* logic/ssm_safing_ctrl.sv */
// Purpose: Independent safing state machine with threshold compare and arming
// Assumes: Host decodes SPI frames; responses arrive as one-cycle strobes
// Notes: Sync and qualifier pins pass three flip-flops
`timescale 1ns/10ps
`default_nettype none
`include "ssm_cfg.svh"

module ssm_safing_ctrl #(
  parameter int unsigned DWELL_SHORT_CYC = `SSM_DWELL_SHORT_MS * 1000 * `SSM_CLK_MHZ,
  parameter int unsigned DWELL_LONG_CYC = `SSM_DWELL_LONG_MS * 1000 * `SSM_CLK_MHZ,
  parameter int unsigned SCRAP_TMO_CYC = `SSM_SCRAP_TMO_US * `SSM_CLK_MHZ,
  parameter int unsigned NUM_SENSORS = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sync_pin,
  input wire logic arming_qualifier_signal,
  input wire logic wdog_ok,
  input wire logic th_wr,
  input wire logic [2:0] th_idx,
  input wire logic [7:0] th_data,
  input wire logic mode_control_command,
  input wire logic [1:0] mode_request_field,
  input wire logic diag_level,
  input wire logic resp_valid,
  input wire logic [3:0] sequence_id_field,
  input wire logic resp_data_ok,
  input wire logic [3:0] resp_sensor,
  input wire logic [7:0] resp_sample,
  input wire logic seed_rd,
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  output logic arming_output_high,
  output logic arming_output_low,
  output logic [2:0] mode_out,
  output logic seq_error,
  output logic [3:0] valid_cnt,
  output logic [7:0] seed_out,
  output logic [7:0] th_rd_data
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] th_sel(input logic [3:0] id);
    th_sel = id[3:1];
  endfunction

  function automatic logic [7:0] key_of(input logic [7:0] s);
    key_of = s ^ `SSM_KEY_MASK;
  endfunction

  // Stages two and three agree: the pin level has settled
  function automatic logic stages_agree(input logic [2:0] sr);
    stages_agree = (sr[1] == sr[2]);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sync_sr_q;
  logic [2:0] qual_sr_q;
  logic sync_lvl_q;
  logic qual_ok_q;
  logic sync_rise;

  // Reset level equals the idle pin level, so no false edge follows reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_sr_q <= 3'h0;
      qual_sr_q <= 3'h0;
    end else begin
      sync_sr_q <= {sync_sr_q[1:0], sync_pin};
      qual_sr_q <= {qual_sr_q[1:0], arming_qualifier_signal};
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_lvl_q <= 1'b0;
      qual_ok_q <= 1'b0;
    end else begin
      if (stages_agree(sync_sr_q)) sync_lvl_q <= sync_sr_q[2];
      if (stages_agree(qual_sr_q)) qual_ok_q <= qual_sr_q[2];
    end
  end

  assign sync_rise = stages_agree(sync_sr_q) && sync_sr_q[2] && !sync_lvl_q;

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  ssm_pkg::ssm_mode_t mode_q;
  logic tmo_hit;
  logic key_match;
  logic [7:0] seed_frz_q;

  assign key_match = (key_data == key_of(seed_frz_q));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= ssm_pkg::SSM_STARTUP;
    end else begin
      unique case (mode_q)
        ssm_pkg::SSM_STARTUP: begin
          if (wdog_ok) mode_q <= ssm_pkg::SSM_DIAG;
        end
        ssm_pkg::SSM_DIAG: begin
          if (mode_control_command && mode_request_field == `SSM_MODE_SAFING) begin
            mode_q <= ssm_pkg::SSM_SAFING;
          end else if (mode_control_command && mode_request_field == `SSM_MODE_SCRAP) begin
            mode_q <= ssm_pkg::SSM_SCRAP;
          end
        end
        ssm_pkg::SSM_SAFING: begin
          // No exit branch: only reset leaves safing
          mode_q <= ssm_pkg::SSM_SAFING;
        end
        ssm_pkg::SSM_SCRAP: begin
          if (key_wr && key_match && qual_ok_q) mode_q <= ssm_pkg::SSM_ARMING;
        end
        ssm_pkg::SSM_ARMING: begin
          if ((key_wr && !key_match) || tmo_hit || !qual_ok_q) begin
            mode_q <= ssm_pkg::SSM_SCRAP;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Seed, key and scrap timeout
  // ----------------------------------------
  logic [7:0] seed_cnt_q;
  logic [$clog2(SCRAP_TMO_CYC + 1)-1:0] tmo_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) seed_cnt_q <= 8'h00;
    else seed_cnt_q <= seed_cnt_q + 8'h01;
  end

  // Freeze the registered value the host saw, not the counter one tick ahead
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) seed_frz_q <= 8'h00;
    else if (seed_rd) seed_frz_q <= seed_out;
  end

  assign tmo_hit = (tmo_q == '0);

  // Refresh reloads; host must refresh before it runs out
  // Held full through scrap, so arming opens with a whole window
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmo_q <= '0;
    end else if (mode_q == ssm_pkg::SSM_SCRAP || (key_wr && key_match)) begin
      tmo_q <= ($bits(tmo_q))'(SCRAP_TMO_CYC);
    end else if (!tmo_hit) begin
      tmo_q <= tmo_q - 1'b1;
    end
  end

  // ----------------------------------------
  // Thresholds
  // ----------------------------------------
  logic [7:0] th_q [8];
  // Bank locks once start-up is left; only reset reopens it

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) th_q[i] <= `SSM_TH_DEFAULT;
    end else if (th_wr && mode_q == ssm_pkg::SSM_STARTUP) begin
      th_q[th_idx] <= th_data;
    end
  end

  // ----------------------------------------
  // Sequence and valid data counters
  // ----------------------------------------
  logic [3:0] seq_q;
  logic [3:0] seq_next;
  logic sens_msg;
  logic seq_err_q;
  logic monitor_on;

  // Sampling only in safing; scrap and start-up ignore the sensor traffic
  assign monitor_on = (mode_q == ssm_pkg::SSM_SAFING);
  assign seq_next = seq_q + 4'h1;
  assign sens_msg = resp_valid && monitor_on && (seq_q != `SSM_SEQ_LAST);

  // Freezing at 1110 keeps late responses out of the counters and the threshold compare
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) seq_q <= `SSM_SEQ_RESET;
    else if (sync_rise) seq_q <= `SSM_SEQ_RESET;
    else if (sens_msg) seq_q <= seq_next;
  end

  logic id_ok;
  assign id_ok = (sequence_id_field == seq_next);

  // Flag stays until next sync; a set in the sync cycle wins over the clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) seq_err_q <= 1'b0;
    else if (sens_msg && !id_ok) seq_err_q <= 1'b1;
    else if (sync_rise) seq_err_q <= 1'b0;
  end

  logic dat_valid;
  logic [3:0] vcnt_q;
  assign dat_valid = sens_msg && resp_data_ok && !seq_err_q && id_ok;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) vcnt_q <= `SSM_CNT_ZERO;
    else if (sync_rise) vcnt_q <= `SSM_CNT_ZERO;
    else if (dat_valid) vcnt_q <= vcnt_q + 4'h1;
  end

  // ----------------------------------------
  // Threshold compare and safing signal
  // ----------------------------------------
  logic [1:0] hits_q [NUM_SENSORS];
  logic [7:0] cur_th;
  logic over;
  logic safing_q;
  logic long_q;

  // Compare uses the seven level bits; the top bit only picks the dwell
  assign cur_th = th_q[th_sel(seq_next)];
  assign over = resp_sample > {1'b0, cur_th[`SSM_TH_MSB-1:0]};

  // Consecutive count per sensor; any below-threshold sample restarts it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_SENSORS; i++) hits_q[i] <= 2'h0;
    end else if (dat_valid) begin
      if (!over) hits_q[resp_sensor] <= 2'h0;
      else if (hits_q[resp_sensor] != `SSM_HITS_NEEDED) hits_q[resp_sensor] <= hits_q[resp_sensor] + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      safing_q <= 1'b0;
      long_q <= 1'b0;
    end else if (dat_valid && over && hits_q[resp_sensor] == `SSM_HITS_NEEDED - 2'h1) begin
      safing_q <= 1'b1;
      long_q <= cur_th[`SSM_TH_MSB];
    end else if (sync_rise || !monitor_on) begin
      safing_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Dwell extension
  // ----------------------------------------
  // Reloads while safing stands; runs down only once it drops
  logic [$clog2(DWELL_LONG_CYC + 1)-1:0] dwell_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) dwell_q <= '0;
    else if (!monitor_on) dwell_q <= '0;
    else if (safing_q) dwell_q <= long_q ? ($bits(dwell_q))'(DWELL_LONG_CYC) :
                                           ($bits(dwell_q))'(DWELL_SHORT_CYC);
    else if (dwell_q != '0) dwell_q <= dwell_q - 1'b1;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic arm_d;
  always_comb begin
    unique case (mode_q)
      ssm_pkg::SSM_SAFING: arm_d = safing_q || (dwell_q != '0);
      ssm_pkg::SSM_ARMING: arm_d = 1'b1;
      default: arm_d = 1'b0;
    endcase
  end

  // Diagnostic ties both pins to one level, so both can never be active
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      arming_output_high <= 1'b0;
      arming_output_low <= 1'b1;
    end else if (mode_q == ssm_pkg::SSM_DIAG) begin
      arming_output_high <= diag_level;
      arming_output_low <= diag_level;
    end else begin
      arming_output_high <= arm_d;
      arming_output_low <= !arm_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) mode_out <= 3'h0;
    else mode_out <= mode_q;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) seq_error <= 1'b0;
    else seq_error <= seq_err_q;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) valid_cnt <= `SSM_CNT_ZERO;
    else valid_cnt <= vcnt_q;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) seed_out <= 8'h00;
    else seed_out <= seed_cnt_q;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) th_rd_data <= `SSM_TH_DEFAULT;
    else th_rd_data <= th_q[th_idx];
  end

endmodule // ssm_safing_ctrl
`default_nettype wire

/* logic/ssm_cfg.svh */
// Purpose: Constants for the safing controller
// Assumes: 250 MHz ref_clk
// Notes: Times in their own units; cycle counts derived
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH
`define SSM_CLK_MHZ 250
`define SSM_DWELL_SHORT_MS 255
`define SSM_DWELL_LONG_MS 2000
`define SSM_SCRAP_TMO_US 600
`define SSM_SEQ_RESET 4'hf
`define SSM_SEQ_LAST 4'he
`define SSM_CNT_ZERO 4'h0
`define SSM_KEY_MASK 8'h55
`define SSM_HITS_NEEDED 2'h3
`define SSM_TH_DEFAULT 8'h0d
`define SSM_TH_MSB 7
`define SSM_MODE_SAFING 2'h1
`define SSM_MODE_SCRAP 2'h2
`endif

/* logic/ssm_pkg.sv */
// Purpose: Types for the safing controller
// Assumes: Nothing
// Notes: Constants live in ssm_cfg.svh
`default_nettype none
package ssm_pkg;
  typedef enum logic [2:0] {
    SSM_STARTUP,
    SSM_DIAG,
    SSM_SAFING,
    SSM_SCRAP,
    SSM_ARMING
  } ssm_mode_t;
endpackage
`default_nettype wire

/* tb/ssm_safing_asserts.sv */
// Purpose: Port checker for the safing controller
// Assumes: Reported mode follows an accepted command by two edges
// Notes: Bound at file end
`timescale 1ns/10ps
`default_nettype none
module ssm_safing_asserts (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic arming_qualifier_signal,
  input wire logic mode_control_command,
  input wire logic [1:0] mode_request_field,
  input wire logic [7:0] seed_out,
  input wire logic arming_output_high,
  input wire logic arming_output_low,
  input wire logic [2:0] mode_out
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  start_quiet_a: assert property (mode_out == 3'h0 |-> !arming_output_high && arming_output_low)
    else $error("outputs active in start-up");
  diag_never_active_a: assert property (mode_out == 3'h1 |-> arming_output_low || !arming_output_high)
    else $error("both outputs active in diagnostic");
  arm_outputs_a: assert property (mode_out == 3'h4 && $past(mode_out) == 3'h4 |-> arming_output_high && !arming_output_low)
    else $error("outputs wrong in arming");
  safing_kept_a: assert property (mode_out == 3'h2 |=> mode_out == 3'h2)
    else $error("left safing without reset");
  diag_to_safing_a: assert property (mode_out == 3'h1 && !$past(mode_control_command)
    && mode_control_command && mode_request_field == 2'h1 |-> ##2 mode_out == 3'h2)
    else $error("no safing entry");
  diag_to_scrap_a: assert property (mode_out == 3'h1 && !$past(mode_control_command)
    && mode_control_command && mode_request_field == 2'h2 |-> ##2 mode_out == 3'h3)
    else $error("no scrap entry");
  scrap_exit_a: assert property (mode_out == 3'h3 |=> mode_out inside {3'h3, 3'h4})
    else $error("bad exit from scrap");
  qual_lost_a: assert property (!arming_qualifier_signal [*7] |-> mode_out != 3'h4)
    else $error("arming held without qualifier");
  seed_runs_a: assert property ($past(rst_b, 2) |-> seed_out == $past(seed_out) + 8'h1)
    else $error("seed counter not free running");
  arm_seen_c: cover property (mode_out == 3'h4);
  safing_fire_c: cover property (mode_out == 3'h2 && arming_output_high);
  arm_drop_c: cover property ($past(mode_out) == 3'h4 && mode_out == 3'h3);
endmodule // ssm_safing_asserts
bind ssm_safing_ctrl ssm_safing_asserts i_ssm_safing_asserts (.ref_clk, .rst_b,
  .arming_qualifier_signal, .mode_control_command, .mode_request_field, .seed_out,
  .arming_output_high, .arming_output_low, .mode_out);
`default_nettype wire

/* tb/ssm_host_model.sv */
// Purpose: Host side sensor response source for one sampling period
// Assumes: Sensor index equals sequence id; with bad set, ids after the first run one ahead
// Notes: Sixteen responses so the last one lands on a frozen counter
`timescale 1ns/10ps
`default_nettype none
module ssm_host_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic bad,
  input wire logic [7:0] big,
  output logic resp_valid,
  output logic [3:0] sequence_id_field,
  output logic resp_data_ok,
  output logic [3:0] resp_sensor,
  output logic [7:0] resp_sample,
  output logic done
);
  logic [4:0] n_q = 5'h10;
  initial {resp_valid, sequence_id_field, resp_data_ok, resp_sensor, resp_sample} = 18'h0;
  assign done = n_q[4];
  always @(posedge ref_clk) begin
    if (go) n_q <= 5'h0;
    else if (!n_q[4]) n_q <= n_q + 5'h1;
    // Fixed order, every source each period
    resp_valid <= !n_q[4];
    sequence_id_field <= n_q[3:0] + {3'h0, bad && n_q != 5'h0};
    resp_sensor <= n_q[3:0];
    resp_data_ok <= 1'h1;
    // Idle data toggles so a stale sample never looks fresh
    resp_sample <= n_q[4] ? ~resp_sample : (n_q[3:0] == 4'he ? big : 8'h02);
  end
endmodule // ssm_host_model
`default_nettype wire

/* tb/tb_ssm_safing_ctrl.sv */
// Purpose: Self-checking bench for the safing controller
// Assumes: Shortened dwell 20/40 and scrap timeout 30 cycles
// Notes: Threshold 7 set to 0x85: long dwell, level 5
`timescale 1ns/10ps
`default_nettype none
module tb_ssm_safing_ctrl;
  logic ref_clk = '0, rst_b = '0, sync_pin = '0, arming_qualifier_signal = '0, wdog_ok = '0;
  logic th_wr = '0, mode_control_command = '0, diag_level = '0, seed_rd = '0, key_wr = '0;
  logic go = '0, bad = '0, done, resp_valid, resp_data_ok, seq_error;
  logic arming_output_high, arming_output_low;
  logic [2:0] th_idx = '0, mode_out;
  logic [1:0] mode_request_field = '0;
  logic [3:0] sequence_id_field, resp_sensor, valid_cnt;
  logic [7:0] th_data = '0, key_data = '0, big = '0, resp_sample, seed_out, th_rd_data, s;
  int n_errors = 0, n_tests = 0;
  always #2 ref_clk = ~ref_clk;
  ssm_safing_ctrl #(.DWELL_SHORT_CYC(20), .DWELL_LONG_CYC(40), .SCRAP_TMO_CYC(30))
    i_ssm_safing_ctrl (.ref_clk, .rst_b, .sync_pin, .arming_qualifier_signal, .wdog_ok,
    .th_wr, .th_idx, .th_data, .mode_control_command, .mode_request_field, .diag_level,
    .resp_valid, .sequence_id_field, .resp_data_ok, .resp_sensor, .resp_sample, .seed_rd,
    .key_wr, .key_data, .arming_output_high, .arming_output_low, .mode_out, .seq_error,
    .valid_cnt, .seed_out, .th_rd_data);
  ssm_host_model i_ssm_host_model (.ref_clk, .go, .bad, .big, .resp_valid,
    .sequence_id_field, .resp_data_ok, .resp_sensor, .resp_sample, .done);
  // ---------
  // Helpers
  // ---------
  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic outs(input logic [7:0] e);
    chk({6'h0, arming_output_high, arming_output_low}, e);
  endtask
  task automatic cmd(input logic [1:0] f);
    mode_request_field <= f;
    mode_control_command <= 1'h1;
    cyc(1);
    mode_control_command <= 1'h0;
    cyc(2);
  endtask
  task automatic wdog;
    wdog_ok <= 1'h1;
    cyc(1);
    wdog_ok <= 1'h0;
    cyc(2);
  endtask
  task automatic key(input logic [7:0] k);
    key_data <= k;
    key_wr <= 1'h1;
    cyc(1);
    key_wr <= 1'h0;
    cyc(3);
  endtask
  // Seed is read, then the counter moves on before the key goes in
  task automatic arm(input logic [7:0] m);
    seed_rd <= 1'h1;
    @(negedge ref_clk) s = seed_out;
    @(posedge ref_clk) seed_rd <= 1'h0;
    cyc(10);
    key(s ^ m);
  endtask
  task automatic sync;
    @(posedge ref_clk) sync_pin <= 1'h1;
    cyc(4);
    sync_pin <= 1'h0;
    cyc(4);
  endtask
  task automatic period(input logic b);
    sync;
    bad <= b;
    go <= 1'h1;
    cyc(1);
    go <= 1'h0;
    cyc(1);
    for (int i = 0; i < 40 && done !== 1'h1; i++) cyc(1);
    if (done !== 1'h1) begin
      n_errors++;
      print_verdict;
    end
    cyc(3);
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_reset;
    rst_b <= 1'h0;
    cyc(3);
    rst_b <= 1'h1;
    cyc(1);
    chk(mode_out, 8'h0);
    outs(8'h01);
    chk(valid_cnt, 8'h0);
    period(1'h1);
    chk(valid_cnt, 8'h0);
    chk(seq_error, 8'h0);
  endtask
  task automatic t_diag;
    th_idx <= 3'h7;
    th_data <= 8'h85;
    th_wr <= 1'h1;
    cyc(1);
    th_wr <= 1'h0;
    cyc(2);
    chk(th_rd_data, 8'h85);
    wdog;
    chk(mode_out, 8'h1);
    th_data <= 8'h11;
    th_wr <= 1'h1;
    cyc(1);
    th_wr <= 1'h0;
    cyc(2);
    chk(th_rd_data, 8'h85);
    diag_level <= 1'h1;
    cyc(3);
    outs(8'h03);
    diag_level <= 1'h0;
    cyc(3);
    outs(8'h00);
  endtask
  task automatic t_safing;
    cmd(2'h1);
    chk(mode_out, 8'h2);
    big <= 8'h06;
    period(1'h0);
    period(1'h0);
    outs(8'h01);
    chk(valid_cnt, 8'hf);
    chk(seq_error, 8'h0);
    period(1'h0);
    outs(8'h02);
    cmd(2'h2);
    chk(mode_out, 8'h2);
    sync;
    cyc(20);
    outs(8'h02);
    cyc(30);
    outs(8'h01);
    period(1'h1);
    chk(seq_error, 8'h1);
    chk(valid_cnt, 8'h1);
    outs(8'h01);
    sync;
    chk(seq_error, 8'h0);
    chk(valid_cnt, 8'h0);
  endtask
  task automatic t_scrap;
    t_reset;
    wdog;
    cmd(2'h2);
    chk(mode_out, 8'h3);
    period(1'h1);
    chk(valid_cnt, 8'h0);
    chk(seq_error, 8'h0);
    arming_qualifier_signal <= 1'h1;
    cmd(2'h1);
    chk(mode_out, 8'h3);
    arm(8'haa);
    chk(mode_out, 8'h3);
    arm(8'h55);
    chk(mode_out, 8'h4);
    outs(8'h02);
    cyc(20);
    key(s ^ 8'h55);
    cyc(20);
    chk(mode_out, 8'h4);
    key(s ^ 8'h54);
    chk(mode_out, 8'h3);
    outs(8'h01);
    arm(8'h55);
    cyc(40);
    chk(mode_out, 8'h3);
    arm(8'h55);
    arming_qualifier_signal <= 1'h0;
    cyc(8);
    chk(mode_out, 8'h3);
  endtask
  initial begin
    t_reset;
    t_diag;
    t_safing;
    t_scrap;
    print_verdict;
  end
endmodule // tb_ssm_safing_ctrl
`default_nettype wire
